// >>> bench/defective_pixel_correction_bench.sv
// self-checking bench for the pixel corrector with a four-entry table
// assumes pixel_source as the sensor and 8 pixels per line
`default_nettype none

module defective_pixel_correction_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dpc_pkg::*;
  localparam int TD = 4;
  localparam int CW = 3;
  localparam int OUTS = 46;

  logic          clk, reset_n, static_en, dynamic_en, start, src_busy;
  logic          pix_valid, pix_ready, pix_sof, out_valid, out_ready;
  logic [7:0]    pix_data, out_data;
  logic          count_wr, x_wr, y_wr, commit, persist, table_busy;
  logic [CW-1:0] count_wdata, count_rdata, sel;
  logic [15:0]   width, off_x, off_y, wdata, x_rd, y_rd;
  logic [7:0]    got[$];
  int            miscompares, cmp_count;

  defective_pixel_correction #(.TABLE_DEPTH(TD)) u_dut (
    .clk(clk), .reset_n(reset_n), .static_en(static_en),
    .dynamic_en(dynamic_en), .repl_mode(REPL_AVERAGE),
    .frame_width(width), .roi_off_x(off_x), .roi_off_y(off_y),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_sof(pix_sof),
    .pix_data(pix_data), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .count_wr(count_wr), .count_wdata(count_wdata),
    .count_rdata(count_rdata), .entry_select_field(sel),
    .coord_x_wr(x_wr), .coord_y_wr(y_wr), .coord_wdata(wdata),
    .coord_x_rdata(x_rd), .coord_y_rdata(y_rd),
    .commit_working_table_cmd(commit), .persist_table_cmd(persist),
    .table_busy(table_busy));

  pixel_source #(.N(64)) u_src (
    .clk(clk), .start(start), .pix_ready(pix_ready),
    .pix_valid(pix_valid), .pix_sof(pix_sof), .pix_data(pix_data),
    .busy(src_busy));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (out_valid && out_ready) got.push_back(out_data);
  end

  ////////////////////////////////////////////////////////////////////////////

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got %h expected %h", $time, g, e);
    end
  endtask

  // op 0 count, 1 x, 2 y, 3 apply, 4 save, else index
  task automatic host(input int op, input logic [15:0] v);
    @(posedge clk);
    case (op)
      0: begin
        count_wr <= 1'b1;
        count_wdata <= v[CW-1:0];
      end
      1: begin
        x_wr <= 1'b1;
        wdata <= v;
      end
      2: begin
        y_wr <= 1'b1;
        wdata <= v;
      end
      3: commit <= 1'b1;
      4: persist <= 1'b1;
      default: sel <= v[CW-1:0];
    endcase
    @(posedge clk);
    {count_wr, x_wr, y_wr, commit, persist} <= 5'h00;
  endtask

  task automatic rd(input logic [15:0] i, input logic [15:0] ex,
                    input logic [15:0] ey);
    host(5, i);
    @(posedge clk);
    #1;
    cmp(x_rd, ex);
    cmp(y_rd, ey);
  endtask

  task automatic busy_len(input int exp);
    int n;
    n = 0;
    #1;
    while (table_busy !== 1'b0) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 200) begin
        miscompares++;
        conclude();
      end
    end
    cmp(16'(n), 16'(exp));
  endtask

  // stall holds the output side off for 80 cycles and checks that the input side is refused
  task automatic run_frame(input logic [7:0] e37, input logic [7:0] e26,
                           input logic [7:0] e20, input bit stall);
    int n;
    bit blocked;
    got.delete();
    blocked = 1'b0;
    @(posedge clk);
    start <= 1'b1;
    out_ready <= !stall;
    @(posedge clk);
    start <= 1'b0;
    for (n = 0; stall && n < 80; n++) begin
      @(posedge clk);
      if (pix_valid && !pix_ready) blocked = 1'b1;
    end
    out_ready <= 1'b1;
    n = 0;
    while (got.size() < OUTS || src_busy) begin
      @(posedge clk);
      n++;
      if (n > 400) begin
        miscompares++;
        conclude();
      end
    end
    repeat (4) @(posedge clk);
    cmp(16'(got.size()), 16'(OUTS));
    if (stall) cmp(16'(blocked), 16'h0001);
    cmp(16'(got[10]), 16'h0064);
    cmp(16'(got[37]), 16'(e37));
    cmp(16'(got[26]), 16'(e26));
    cmp(16'(got[20]), 16'(e20));
  endtask

  ////////////////////////////////////////////////////////////////////////////

  task automatic edit_table();
    host(0, 16'h0001);
    host(5, 16'h0000);
    host(1, 16'h0008);
    host(2, 16'h0005);
    rd(16'h0000, 16'h0008, 16'h0005);
    cmp(16'(count_rdata), 16'h0001);
    rd(16'h0001, 16'h0000, 16'h0000);
    // entry 1 names pixel 26; it must stay unused while the count is 1
    host(0, 16'h0002);
    host(1, 16'h0005);
    host(2, 16'h0004);
    host(0, 16'h0001);
    host(1, 16'h0009);
    rd(16'h0001, 16'h0000, 16'h0000);
    host(0, 16'h0002);
    rd(16'h0001, 16'h0005, 16'h0004);
    host(0, 16'h0001);
    host(0, 16'h0005);
    rd(16'h0000, 16'h0008, 16'h0005);
    cmp(16'(count_rdata), 16'h0001);
  endtask

  task automatic apply_check();
    @(posedge clk);
    static_en <= 1'b1;
    run_frame(8'h6e, 8'hfa, 8'h00, 1'b0);
    host(3, 16'h0000);
    busy_len(TD);
    run_frame(8'h64, 8'hfa, 8'h00, 1'b1);
  endtask

  task automatic enable_check();
    static_en <= 1'b0;
    run_frame(8'h6e, 8'hfa, 8'h00, 1'b0);
    dynamic_en <= 1'b1;
    run_frame(8'h6e, 8'h64, 8'h64, 1'b0);
    static_en <= 1'b1;
    run_frame(8'h64, 8'h64, 8'h64, 1'b0);
    dynamic_en <= 1'b0;
  endtask

  task automatic save_boot_check();
    host(4, 16'h0000);
    busy_len(TD);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    busy_len(TD);
    rd(16'h0000, 16'h0008, 16'h0005);
    cmp(16'(count_rdata), 16'h0001);
    run_frame(8'h64, 8'hfa, 8'h00, 1'b0);
  endtask

  initial begin
    reset_n = 1'b0;
    {static_en, dynamic_en, start, out_ready} = 4'h1;
    {count_wr, x_wr, y_wr, commit, persist} = 5'h00;
    count_wdata = '0;
    sel = '0;
    wdata = 16'h0000;
    width = 16'h0008;
    off_x = 16'h0003;
    off_y = 16'h0001;
    miscompares = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    busy_len(TD);
    cmp(16'(count_rdata), 16'h0000);
    edit_table();
    apply_check();
    enable_check();
    save_boot_check();
    conclude();
  end
endmodule

`default_nettype wire

// >>> bench/pixel_source.sv
// sensor-side model: sends one raster frame of 64 pixels per start pulse
// assumes the block samples the handshake on the rising edge of clk
`default_nettype none

module pixel_source #(
  parameter int N = 64
) (
  input  wire logic  clk,
  input  wire logic  start,
  input  wire logic  pix_ready,
  output logic       pix_valid,
  output logic       pix_sof,
  output logic [7:0] pix_data,
  output logic       busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int n;

  // flat level with a warm spot, a hot spot and a dark spot
  function automatic logic [7:0] level(input int k);
    case (k)
      37: return 8'h6e;
      26: return 8'hfa;
      20: return 8'h00;
      default: return 8'h64;
    endcase
  endfunction

  initial begin
    pix_valid = 1'b0;
    pix_sof = 1'b0;
    pix_data = 8'h00;
    busy = 1'b0;
    n = 0;
  end

  // request held until accepted; released data shows the inverse
  always @(posedge clk) begin
    if (!busy && start) begin
      busy <= 1'b1;
      pix_valid <= 1'b1;
      pix_sof <= 1'b1;
      pix_data <= level(0);
      n <= 1;
    end else if (busy && pix_valid && pix_ready) begin
      pix_sof <= 1'b0;
      n <= n + 1;
      if (n == N) begin
        busy <= 1'b0;
        pix_valid <= 1'b0;
        pix_data <= ~pix_data;
      end else begin
        pix_data <= level(n);
      end
    end
  end
endmodule

`default_nettype wire

// >>> src/defective_pixel_correction.sv
// pixel corrector with static table, dynamic outlier filter and output fifo
// assumes pixels arrive in raster order, pix_sof on the first of each frame
`default_nettype none

module dpc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  assign in_ready  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wp_d  = push ? wp_q + 1'b1 : wp_q;
    rp_d  = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wp_q] <= in_data;
  end
endmodule

////////////////////////////////////////////////////////////////////////////

module defective_pixel_correction #(
  parameter int          PIX_W       = 8,
  parameter int          COORD_W     = 16,
  parameter int          LINE_MAX    = 2048,
  parameter int          TABLE_DEPTH = 32,
  parameter int          FIFO_DEPTH  = 32,
  parameter int unsigned DYN_THRESH  = 32,
  parameter int          CNT_W       = $clog2(TABLE_DEPTH+1)
) (
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               static_en,
  input  wire logic               dynamic_en,
  input  wire dpc_pkg::repl_mode_t repl_mode,
  input  wire logic [COORD_W-1:0] frame_width,
  input  wire logic [COORD_W-1:0] roi_off_x,
  input  wire logic [COORD_W-1:0] roi_off_y,
  input  wire logic               pix_valid,
  output logic                    pix_ready,
  input  wire logic               pix_sof,
  input  wire logic [PIX_W-1:0]   pix_data,
  output logic                    out_valid,
  input  wire logic               out_ready,
  output logic [PIX_W-1:0]        out_data,
  input  wire logic               count_wr,
  input  wire logic [CNT_W-1:0]   count_wdata,
  output logic [CNT_W-1:0]        count_rdata,
  input  wire logic [CNT_W-1:0]   entry_select_field,
  input  wire logic               coord_x_wr,
  input  wire logic               coord_y_wr,
  input  wire logic [COORD_W-1:0] coord_wdata,
  output logic [COORD_W-1:0]      coord_x_rdata,
  output logic [COORD_W-1:0]      coord_y_rdata,
  input  wire logic               commit_working_table_cmd,
  input  wire logic               persist_table_cmd,
  output logic                    table_busy
);
  import dpc_pkg::*;
  localparam int IW = $clog2(TABLE_DEPTH);
  localparam int LW = $clog2(LINE_MAX);
  localparam int TD = TABLE_DEPTH;
  localparam int SW = PIX_W + AVG_SH;

  //////////////////////////////////////////////////////////////////////////
  // defect tables: staging, volatile working, persistent

  logic [COORD_W-1:0] stg_x [TABLE_DEPTH];
  logic [COORD_W-1:0] stg_y [TABLE_DEPTH];
  logic [COORD_W-1:0] wrk_x [TABLE_DEPTH];
  logic [COORD_W-1:0] wrk_y [TABLE_DEPTH];
  logic [COORD_W-1:0] nv_x  [TABLE_DEPTH];
  logic [COORD_W-1:0] nv_y  [TABLE_DEPTH];
  logic [CNT_W-1:0]   nv_cnt_q = '0;
  logic [CNT_W-1:0]   stg_cnt_q, stg_cnt_d, wrk_cnt_q, wrk_cnt_d;
  logic [COORD_W-1:0] rx_q, rx_d, ry_q, ry_d;
  copy_state_t        st_q, st_d;
  logic [IW-1:0]      ptr_q, ptr_d;
  logic               idle, sel_ok, last;
  logic [IW-1:0]      sel;

  assign idle   = st_q == ST_IDLE;
  assign sel_ok = entry_select_field < stg_cnt_q;
  assign sel    = entry_select_field[IW-1:0];
  assign last   = ptr_q == IW'(TABLE_DEPTH-1);

  always_comb begin
    st_d      = st_q;
    ptr_d     = ptr_q;
    stg_cnt_d = stg_cnt_q;
    wrk_cnt_d = wrk_cnt_q;
    rx_d      = sel_ok ? stg_x[sel] : '0;
    ry_d      = sel_ok ? stg_y[sel] : '0;
    unique case (st_q)
      ST_IDLE: begin
        ptr_d = '0;
        if (commit_working_table_cmd) st_d = ST_APPLY;
        else if (persist_table_cmd) st_d = ST_SAVE;
        else if (count_wr && count_wdata <= CNT_W'(TABLE_DEPTH))
          stg_cnt_d = count_wdata;
      end
      ST_BOOT, ST_APPLY, ST_SAVE: begin
        ptr_d = ptr_q + 1'b1;
        if (last) begin
          st_d = ST_IDLE;
          if (st_q == ST_BOOT) begin
            wrk_cnt_d = nv_cnt_q;
            stg_cnt_d = nv_cnt_q;
          end
          if (st_q == ST_APPLY) wrk_cnt_d = stg_cnt_q;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q      <= STATE_RST;
      ptr_q     <= '0;
      stg_cnt_q <= '0;
      wrk_cnt_q <= '0;
      rx_q      <= '0;
      ry_q      <= '0;
    end else begin
      st_q      <= st_d;
      ptr_q     <= ptr_d;
      stg_cnt_q <= stg_cnt_d;
      wrk_cnt_q <= wrk_cnt_d;
      rx_q      <= rx_d;
      ry_q      <= ry_d;
    end
  end

  // table memories hold no reset; the persistent copy survives reset_n
  always_ff @(posedge clk) begin
    if (idle && coord_x_wr && sel_ok) stg_x[sel] <= coord_wdata;
    if (idle && coord_y_wr && sel_ok) stg_y[sel] <= coord_wdata;
    if (st_q == ST_BOOT) begin
      wrk_x[ptr_q] <= nv_x[ptr_q];
      wrk_y[ptr_q] <= nv_y[ptr_q];
      stg_x[ptr_q] <= nv_x[ptr_q];
      stg_y[ptr_q] <= nv_y[ptr_q];
    end
    if (st_q == ST_APPLY) begin
      wrk_x[ptr_q] <= stg_x[ptr_q];
      wrk_y[ptr_q] <= stg_y[ptr_q];
    end
    if (st_q == ST_SAVE) begin
      nv_x[ptr_q] <= stg_x[ptr_q];
      nv_y[ptr_q] <= stg_y[ptr_q];
      if (last) nv_cnt_q <= stg_cnt_q;
    end
  end

  assign count_rdata   = stg_cnt_q;
  assign coord_x_rdata = rx_q;
  assign coord_y_rdata = ry_q;
  assign table_busy    = !idle;

  //////////////////////////////////////////////////////////////////////////
  // raster position, line buffers and 5x5 window

  logic [PIX_W-1:0]   win_q [WIN][WIN];
  logic [PIX_W-1:0]   win_d [WIN][WIN];
  logic [PIX_W-1:0]   lb [WIN-1][LINE_MAX];
  logic [PIX_W-1:0]   col [WIN];
  logic [COORD_W-1:0] x_q, x_d, y_q, y_d, cx_q, cx_d, cy_q, cy_d;
  logic [COORD_W-1:0] in_x, in_y;
  logic               emit_q, emit_d, warm, accept, fifo_ready;

  assign in_x      = pix_sof ? '0 : x_q;
  assign in_y      = pix_sof ? '0 : y_q;
  assign pix_ready = !emit_q || fifo_ready;
  assign accept    = pix_valid && pix_ready;
  assign warm      = in_y > COORD_W'(CTR) ||
                     (in_y == COORD_W'(CTR) && in_x >= COORD_W'(CTR));

  always_comb begin
    x_d    = x_q;
    y_d    = y_q;
    cx_d   = cx_q;
    cy_d   = cy_q;
    emit_d = emit_q && !fifo_ready;
    col[WIN-1] = pix_data;
    for (int r = 0; r < WIN-1; r++)
      col[r] = lb[r][in_x[LW-1:0]];
    for (int r = 0; r < WIN; r++)
      for (int c = 0; c < WIN; c++)
        win_d[r][c] = win_q[r][c];
    if (accept) begin
      emit_d = warm;
      x_d = in_x + 1'b1;
      y_d = in_y;
      if (x_d >= frame_width) begin
        x_d = '0;
        y_d = in_y + 1'b1;
      end
      // centre sits two lines and two pixels behind the input
      if (in_x >= COORD_W'(CTR)) begin
        cx_d = in_x - COORD_W'(CTR);
        cy_d = in_y - COORD_W'(CTR);
      end else begin
        cx_d = in_x + frame_width - COORD_W'(CTR);
        cy_d = in_y - COORD_W'(CTR+1);
      end
      for (int r = 0; r < WIN; r++) begin
        for (int c = 0; c < WIN-1; c++)
          win_d[r][c] = win_q[r][c+1];
        win_d[r][WIN-1] = col[r];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      x_q    <= '0;
      y_q    <= '0;
      cx_q   <= '0;
      cy_q   <= '0;
      emit_q <= 1'b0;
      for (int r = 0; r < WIN; r++)
        for (int c = 0; c < WIN; c++)
          win_q[r][c] <= '0;
    end else begin
      x_q    <= x_d;
      y_q    <= y_d;
      cx_q   <= cx_d;
      cy_q   <= cy_d;
      emit_q <= emit_d;
      win_q  <= win_d;
    end
  end

  always_ff @(posedge clk) begin
    if (accept) begin
      lb[WIN-2][in_x[LW-1:0]] <= pix_data;
      for (int r = 0; r < WIN-2; r++)
        lb[r][in_x[LW-1:0]] <= lb[r+1][in_x[LW-1:0]];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // correction of the window centre

  logic [PIX_W-1:0]   ctr, avg, mx, mn, fifo_din;
  logic [SW-1:0]      sum8;
  logic [COORD_W-1:0] fx, fy;
  logic               hit, hot, cold, interior, fix;

  assign ctr = win_q[CTR][CTR];
  assign fx  = cx_q + roi_off_x;
  assign fy  = cy_q + roi_off_y;
  assign interior = cx_q >= COORD_W'(CTR) &&
                    (cx_q + COORD_W'(CTR)) < frame_width;

  always_comb begin
    sum8 = '0;
    mx   = '0;
    mn   = '1;
    hit  = 1'b0;
    for (int r = 0; r < WIN; r++)
      for (int c = 0; c < WIN; c++)
        if (r != CTR || c != CTR) begin
          if (win_q[r][c] > mx) mx = win_q[r][c];
          if (win_q[r][c] < mn) mn = win_q[r][c];
          if (r >= CTR-1 && r <= CTR+1 && c >= CTR-1 && c <= CTR+1)
            sum8 = sum8 + SW'(win_q[r][c]);
        end
    for (int i = 0; i < TABLE_DEPTH; i++)
      if (CNT_W'(i) < wrk_cnt_q && wrk_x[i] == fx && wrk_y[i] == fy)
        hit = 1'b1;
  end

  assign avg  = sum8[SW-1:AVG_SH];
  assign hot  = {1'b0, ctr} > {1'b0, mx} + (PIX_W+1)'(DYN_THRESH);
  assign cold = {1'b0, ctr} + (PIX_W+1)'(DYN_THRESH) < {1'b0, mn};
  assign fix  = interior &&
                ((static_en && hit && repl_mode == REPL_AVERAGE) ||
                 (dynamic_en && (hot || cold)));
  assign fifo_din = fix ? avg : ctr;

  dpc_fifo #(
    .W     (PIX_W),
    .DEPTH (FIFO_DEPTH)
  ) out_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (emit_q),
    .in_ready  (fifo_ready),
    .in_data   (fifo_din),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_pass_off: assert property (
    emit_q && !static_en && !dynamic_en |-> fifo_din == ctr)
    else $error("pixel changed with both corrections off");
  chk_dyn_indep: assert property (
    emit_q && !dynamic_en && !hit |-> fifo_din == ctr)
    else $error("unlisted pixel changed with dynamic off");
  chk_static_avg: assert property (
    emit_q && static_en && hit && interior |-> fifo_din == avg)
    else $error("listed pixel not replaced by average");
  chk_hot_cold: assert property (
    emit_q && dynamic_en && interior && (hot || cold) |-> fifo_din == avg)
    else $error("outlier pixel not corrected");
  chk_apply_end: assert property (
    st_q == ST_APPLY && last |=> idle && wrk_cnt_q == $past(stg_cnt_q))
    else $error("apply did not set working count");
  chk_apply_time: assert property (
    $rose(st_q == ST_APPLY) |-> ##[1:TD] idle)
    else $error("apply copy too long");
  chk_stage_only: assert property (
    idle && !commit_working_table_cmd |=> $stable(wrk_cnt_q))
    else $error("working table changed without apply");
  chk_save_end: assert property (
    st_q == ST_SAVE && last |=> nv_cnt_q == $past(stg_cnt_q))
    else $error("save did not store count");
  chk_range_zero: assert property (
    !sel_ok |=> coord_x_rdata == '0 && coord_y_rdata == '0)
    else $error("out of range entry read non-zero");
  chk_count_wr: assert property (
    idle && !commit_working_table_cmd && !persist_table_cmd && count_wr &&
    count_wdata <= CNT_W'(TABLE_DEPTH) |=> count_rdata == $past(count_wdata))
    else $error("count write not taken");
endmodule

`default_nettype wire

// >>> src/dpc_pkg.sv
// shared types and constants of the defective pixel correction block
// assumes one pixel clock and an asynchronous active-low reset
//
// Overview of operation
// - With static correction on, listed pixels with at least two columns on each side take the mean of their neighbours.
// - With dynamic correction on, a 5x5 outlier pixel with at least two columns on each side is corrected.
// - Dynamic correction fixes both too-bright and too-dark pixels.
// - Static enable turns table correction on; off, listed pixels pass.
// - The dynamic enable works independently of the static enable.
// - The replacement method selects averaging, the mean of the neighbours.
// - The count sets the number of valid entries and reads back.
// - The entry index is zero based and runs from 0 to count minus one.
// - X and Y settings read and write the entry chosen by the index.
// - Table coordinates are full-sensor, crop offsets added back.
// - Edits go to a staging table and leave the output alone until apply.
// - Apply copies the staging table into the volatile working table.
// - Save stores the table persistently; every boot loads it back.
// - During an apply the output may be briefly wrong until the copy ends.
`default_nettype none

package dpc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_BOOT  = 2'b11,
    ST_APPLY = 2'b01,
    ST_SAVE  = 2'b10
  } copy_state_t;

  typedef enum logic {
    REPL_AVERAGE = 1'b0
  } repl_mode_t;

  // window geometry: centre row/column and border width
  localparam int WIN      = 5;
  localparam int CTR      = 2;
  localparam int AVG_SH   = 3;
  localparam copy_state_t STATE_RST = ST_BOOT;

endpackage

`default_nettype wire
